//--- include/irq_flags_pkg.sv
// Constants and carrier types of the request and error flag block
// ****************************************************************
// Function
// - General write bit 7 sets or clears marked
// - Transmit-done request set after last bit
// - Receive-done request set on valid stream end
// - Byte-required option gates receive-done on FIFO
// - Command self-termination to idle sets command-end
// - Unknown command returns idle, sets command-end
// - Host writing idle raises no command-end
// - FIFO high level latched until host clears
// - FIFO low level latched until host clears
// - Any newly set error raises error request
// - Timer reaching zero raises timer request
// - Aux write bit 7 sets or clears marked
// - Aux input edges raise activity request
// - Checksum done during checksum command raises request
// - Aux request register at 05h, reserved bits
// - Read-only error register 06h, reset 00h
// - Errors reflect the most recent command
// - General request register 04h, reset 14h
// - Enabled requests combine into interrupt status
// - Polarity option inverts the interrupt pin
// - Command start clears errors except overheat
// ****************************************************************
package irq_flags_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [5:0] CMD_ADDR       = 6'h01;
	localparam logic [5:0] GEN_EN_ADDR    = 6'h02;
	localparam logic [5:0] AUX_EN_ADDR    = 6'h03;
	localparam logic [5:0] GEN_REQ_ADDR   = 6'h04;
	localparam logic [5:0] AUX_REQ_ADDR   = 6'h05;
	localparam logic [5:0] ERR_ADDR       = 6'h06;
	localparam logic [5:0] STATUS_ADDR    = 6'h07;
	localparam logic [5:0] RX_MODE_ADDR   = 6'h20;

	// ****************************************************************
	// Reset values and field layout
	// ****************************************************************
	localparam logic [7:0] GEN_EN_RST     = 8'h80;
	localparam logic [7:0] AUX_EN_RST     = 8'h00;
	localparam logic [6:0] GEN_REQ_RST    = 7'h14;
	localparam logic [6:0] AUX_REQ_RST    = 7'h00;
	localparam logic [7:0] ERR_RST        = 8'h00;
	localparam logic [6:0] AUX_REQ_MASK   = 7'h14;
	localparam logic [7:0] ERR_MASK       = 8'hDF;
	localparam logic [7:0] ERR_KEEP_MASK  = 8'h40;
	localparam int         SEL_BIT        = 7;
	localparam int         TX_BIT         = 6;
	localparam int         RX_BIT         = 5;
	localparam int         CMD_END_BIT    = 4;
	localparam int         FIFO_HI_BIT    = 3;
	localparam int         FIFO_LO_BIT    = 2;
	localparam int         ERR_BIT        = 1;
	localparam int         TIMER_BIT      = 0;
	localparam int         AUX_EDGE_BIT   = 4;
	localparam int         CRC_BIT        = 2;
	localparam int         INV_BIT        = 7;
	localparam int         ST_IRQ_BIT     = 4;
	localparam int         ST_HI_BIT      = 1;
	localparam int         ST_LO_BIT      = 0;
	localparam logic [3:0] IDLE_CMD       = 4'h0;

	// ****************************************************************
	// Event carrier from the internal units
	// ****************************************************************
	typedef struct packed {
		logic tx_last_bit;
		logic rx_stream_end;
		logic cmd_finished;
		logic timer_zero;
		logic crc_data_done;
	} unit_events_t;

endpackage : irq_flags_pkg

//--- hdl/irq_flags.sv
// Request, error flag and interrupt pin logic of the reader core
`timescale 1ns/1ps

module irq_flags
	import irq_flags_pkg::*;
#(
	parameter logic [3:0]  CRC_CMD    = 4'h3,
	parameter logic [15:0] KNOWN_CMDS = 16'hFFFF
) (
	// Clock and reset
	input  wire logic         CLK_I,
	input  wire logic         SRST_I,
	// Register port
	input  wire logic [5:0]   ADDR_I,
	input  wire logic [7:0]   WDATA_I,
	input  wire logic         WR_I,
	input  wire logic         RD_I,
	output logic      [7:0]   RDATA_O,
	// Internal unit events and levels
	input  wire unit_events_t EVT_I,
	input  wire logic         FIFO_HAS_BYTES_I,
	input  wire logic         FIFO_HIGH_I,
	input  wire logic         FIFO_LOW_I,
	input  wire logic         AUX_SERIAL_I,
	input  wire logic [7:0]   ERR_SET_I,
	// Command and interrupt outputs
	output logic      [3:0]   CMD_O,
	output logic              CMD_START_O,
	output logic              IRQ_O
);

	// ****************************************************************
	// Decode
	// ****************************************************************
	function automatic logic wr_at(input logic wr, input logic [5:0] ad, input logic [5:0] a);
		wr_at = wr && (ad == a);
	endfunction : wr_at

	logic [3:0] cmd;
	logic [7:0] gen_en;
	logic [7:0] aux_en;
	logic [6:0] gen_req;
	logic [6:0] aux_req;
	logic [7:0] err;
	logic       rx_requires_bytes;
	logic       aux_prev;
	logic       irq_bit;

	logic       wr_cmd;
	logic       wr_gen;
	logic       wr_aux;
	logic       cmd_known;
	logic       cmd_start;
	logic       cmd_unknown;
	logic       cmd_self_end;
	logic [7:0] next_err;
	logic [6:0] gen_hw;
	logic [6:0] aux_hw;
	logic [6:0] next_gen_req;
	logic [6:0] next_aux_req;
	logic       next_irq;

	assign wr_cmd       = wr_at(WR_I, ADDR_I, CMD_ADDR);
	assign wr_gen       = wr_at(WR_I, ADDR_I, GEN_REQ_ADDR);
	assign wr_aux       = wr_at(WR_I, ADDR_I, AUX_REQ_ADDR);
	assign cmd_known    = KNOWN_CMDS[WDATA_I[3:0]];
	assign cmd_start    = wr_cmd && (WDATA_I[3:0] != IDLE_CMD);
	assign cmd_unknown  = cmd_start && !cmd_known;
	// Host writes win over a simultaneous self-termination
	assign cmd_self_end = EVT_I.cmd_finished && (cmd != IDLE_CMD) && !wr_cmd;

	// ****************************************************************
	// Command field
	// ****************************************************************
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			cmd <= IDLE_CMD;
		end else if (wr_cmd) begin
			cmd <= cmd_known ? WDATA_I[3:0] : IDLE_CMD;
		end else if (cmd_self_end) begin
			cmd <= IDLE_CMD;
		end
	end

	// ****************************************************************
	// Enables and option bits
	// ****************************************************************
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			gen_en            <= GEN_EN_RST;
			aux_en            <= AUX_EN_RST;
			rx_requires_bytes <= 1'b0;
		end else begin
			if (wr_at(WR_I, ADDR_I, GEN_EN_ADDR)) begin
				gen_en <= WDATA_I;
			end
			if (wr_at(WR_I, ADDR_I, AUX_EN_ADDR)) begin
				aux_en <= WDATA_I & {1'b1, AUX_REQ_MASK};
			end
			if (wr_at(WR_I, ADDR_I, RX_MODE_ADDR)) begin
				rx_requires_bytes <= WDATA_I[0];
			end
		end
	end

	// ****************************************************************
	// Error flags
	// ****************************************************************
	always_comb begin
		next_err = cmd_start ? (err & ERR_KEEP_MASK) : err;
		next_err = (next_err | ERR_SET_I) & ERR_MASK;
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			err <= ERR_RST;
		end else begin
			err <= next_err;
		end
	end

	// ****************************************************************
	// Request registers
	// ****************************************************************
	always_comb begin
		gen_hw = '0;
		gen_hw[TX_BIT]      = EVT_I.tx_last_bit;
		gen_hw[RX_BIT]      = EVT_I.rx_stream_end && (!rx_requires_bytes || FIFO_HAS_BYTES_I);
		// host idle write is not an end
		gen_hw[CMD_END_BIT] = cmd_self_end || cmd_unknown;
		gen_hw[FIFO_HI_BIT] = FIFO_HIGH_I;
		gen_hw[FIFO_LO_BIT] = FIFO_LOW_I;
		gen_hw[ERR_BIT]     = |(next_err & ~err);
		gen_hw[TIMER_BIT]   = EVT_I.timer_zero;
		aux_hw = '0;
		aux_hw[AUX_EDGE_BIT] = AUX_SERIAL_I ^ aux_prev;
		aux_hw[CRC_BIT]      = EVT_I.crc_data_done && (cmd == CRC_CMD);
	end

	// Hardware set beats a host clear in the same cycle
	always_comb begin
		next_gen_req = gen_req | gen_hw;
		next_aux_req = aux_req | aux_hw;
		if (wr_gen) begin
			next_gen_req = WDATA_I[SEL_BIT] ? (gen_req | WDATA_I[6:0] | gen_hw)
			                                : ((gen_req & ~WDATA_I[6:0]) | gen_hw);
		end
		if (wr_aux) begin
			next_aux_req = WDATA_I[SEL_BIT] ? (aux_req | WDATA_I[6:0] | aux_hw)
			                                : ((aux_req & ~WDATA_I[6:0]) | aux_hw);
		end
		next_aux_req = next_aux_req & AUX_REQ_MASK;
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			gen_req <= GEN_REQ_RST;
			aux_req <= AUX_REQ_RST;
		end else begin
			gen_req <= next_gen_req;
			aux_req <= next_aux_req;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			// Track the pin in reset too, so no false edge follows
			aux_prev <= AUX_SERIAL_I;
		end else begin
			aux_prev <= AUX_SERIAL_I;
		end
	end

	// ****************************************************************
	// Interrupt combine and pin
	// ****************************************************************
	// enabled requests only
	assign next_irq = |(gen_req & gen_en[6:0]) || |(aux_req & aux_en[6:0]);

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			irq_bit <= 1'b0;
			IRQ_O   <= GEN_EN_RST[INV_BIT];
		end else begin
			irq_bit <= next_irq;
			IRQ_O   <= next_irq ^ gen_en[INV_BIT];
		end
	end

	// ****************************************************************
	// Read port and command outputs
	// ****************************************************************
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			RDATA_O <= 8'h00;
		end else if (RD_I) begin
			unique case (ADDR_I)
				CMD_ADDR:     RDATA_O <= {4'h0, cmd};
				GEN_EN_ADDR:  RDATA_O <= gen_en;
				AUX_EN_ADDR:  RDATA_O <= aux_en;
				GEN_REQ_ADDR: RDATA_O <= {1'b0, gen_req};
				AUX_REQ_ADDR: RDATA_O <= {1'b0, aux_req};
				ERR_ADDR:     RDATA_O <= err;
				STATUS_ADDR:  RDATA_O <= {3'h0, irq_bit, 2'h0, FIFO_HIGH_I, FIFO_LOW_I};
				RX_MODE_ADDR: RDATA_O <= {7'h00, rx_requires_bytes};
				default:      RDATA_O <= 8'h00;
			endcase
		end else begin
			RDATA_O <= 8'h00;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			CMD_START_O <= 1'b0;
		end else begin
			CMD_START_O <= cmd_start && cmd_known;
		end
	end

	assign CMD_O = cmd;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SRST_I);

	sequence s_set_write;
		wr_gen && WDATA_I[SEL_BIT];
	endsequence

	sequence s_unknown_start;
		wr_cmd && (WDATA_I[3:0] != IDLE_CMD) && !KNOWN_CMDS[WDATA_I[3:0]];
	endsequence

	chk_set_select: assert property (s_set_write |=>
		(gen_req & $past(WDATA_I[6:0])) == $past(WDATA_I[6:0]))
		else $error("marked request bits not set");

	chk_tx_request: assert property (EVT_I.tx_last_bit |=> gen_req[TX_BIT])
		else $error("transmit done request missing");

	chk_rx_gate: assert property (EVT_I.rx_stream_end && rx_requires_bytes
		&& !FIFO_HAS_BYTES_I && !gen_req[RX_BIT] && !wr_gen |=> !gen_req[RX_BIT])
		else $error("receive done set without bytes");

	chk_unknown_cmd: assert property (s_unknown_start |=>
		(cmd == IDLE_CMD) && gen_req[CMD_END_BIT])
		else $error("unknown command not returned to idle");

	chk_idle_write: assert property (wr_cmd && (WDATA_I[3:0] == IDLE_CMD)
		&& !gen_req[CMD_END_BIT] && !wr_gen |=> !gen_req[CMD_END_BIT])
		else $error("host idle write raised command end");

	chk_fifo_hold: assert property (gen_req[FIFO_HI_BIT]
		&& !(wr_gen && !WDATA_I[SEL_BIT] && WDATA_I[FIFO_HI_BIT]) |=> gen_req[FIFO_HI_BIT])
		else $error("fifo high request lost");

	chk_err_request: assert property (|(next_err & ~err) |=> gen_req[ERR_BIT])
		else $error("error request missing");

	chk_aux_edge: assert property ($changed(AUX_SERIAL_I) |=> aux_req[AUX_EDGE_BIT])
		else $error("aux edge request missing");

	chk_err_clear: assert property (cmd_start ##1 (ERR_SET_I == 8'h00) |->
		((err & ~ERR_KEEP_MASK) & ~$past(ERR_SET_I)) == 8'h00)
		else $error("errors not cleared on start");

	chk_irq_pin: assert property (##1 1'b1 |-> IRQ_O == (irq_bit ^ $past(gen_en[INV_BIT])))
		else $error("interrupt pin polarity wrong");

	chk_aux_reserved: assert property ((aux_req & ~AUX_REQ_MASK) == 7'h00)
		else $error("reserved aux bit set");

	sequence s_clear_write;
		wr_gen && !WDATA_I[SEL_BIT] && ((gen_hw & WDATA_I[6:0]) == 7'h00);
	endsequence

	sequence s_self_end;
		EVT_I.cmd_finished && (cmd != IDLE_CMD) && !wr_cmd;
	endsequence

	chk_clear_select: assert property (s_clear_write |=>
		(gen_req & $past(WDATA_I[6:0])) == 7'h00)
		else $error("marked request bits not cleared");

	chk_rx_request: assert property (EVT_I.rx_stream_end
		&& (!rx_requires_bytes || FIFO_HAS_BYTES_I) |=> gen_req[RX_BIT])
		else $error("receive done request missing");

	chk_cmd_end: assert property (s_self_end |=>
		(cmd == IDLE_CMD) && gen_req[CMD_END_BIT])
		else $error("command end request missing");

	chk_fifo_high_latch: assert property (FIFO_HIGH_I |=> gen_req[FIFO_HI_BIT])
		else $error("fifo high request not latched");

	chk_fifo_low_latch: assert property (FIFO_LOW_I |=> gen_req[FIFO_LO_BIT])
		else $error("fifo low request not latched");

	chk_fifo_low_hold: assert property (gen_req[FIFO_LO_BIT]
		&& !(wr_gen && !WDATA_I[SEL_BIT] && WDATA_I[FIFO_LO_BIT]) |=> gen_req[FIFO_LO_BIT])
		else $error("fifo low request lost");

	chk_timer_request: assert property (EVT_I.timer_zero |=> gen_req[TIMER_BIT])
		else $error("timer request missing");

	chk_aux_select: assert property (wr_aux && WDATA_I[SEL_BIT] |=>
		(aux_req & $past(WDATA_I[6:0]) & AUX_REQ_MASK) == ($past(WDATA_I[6:0]) & AUX_REQ_MASK))
		else $error("marked aux request bits not set");

	chk_crc_request: assert property (EVT_I.crc_data_done && (cmd == CRC_CMD)
		|=> aux_req[CRC_BIT])
		else $error("checksum done request missing");

	chk_err_reserved: assert property ((err & ~ERR_MASK) == 8'h00)
		else $error("reserved error bit set");

	chk_irq_quiet: assert property (((gen_req & gen_en[6:0]) == 7'h00)
		&& ((aux_req & aux_en[6:0]) == 7'h00) |=> !irq_bit)
		else $error("interrupt status without enabled request");

	chk_irq_raise: assert property ((gen_req & gen_en[6:0]) != 7'h00 |=> irq_bit)
		else $error("interrupt status missing");

	chk_start_pulse: assert property (wr_cmd && (WDATA_I[3:0] != IDLE_CMD)
		&& KNOWN_CMDS[WDATA_I[3:0]] |=> CMD_START_O && (cmd == $past(WDATA_I[3:0])))
		else $error("command start not taken");

endmodule : irq_flags

//--- bench/irq_flags_bench.sv
// Self-checking bench of the request and error flag block
`timescale 1ns/1ps

module irq_flags_bench;
	import irq_flags_pkg::*;

	// ****************************************************************
	// Signals
	// ****************************************************************
	logic         CLK_I            = 1'b0;
	logic         SRST_I           = 1'b1;
	logic [5:0]   ADDR_I           = 6'h00;
	logic [7:0]   WDATA_I          = 8'h00;
	logic         WR_I             = 1'b0;
	logic         RD_I             = 1'b0;
	unit_events_t EVT_I            = '0;
	logic         FIFO_HAS_BYTES_I = 1'b0;
	logic         FIFO_HIGH_I      = 1'b0;
	logic         FIFO_LOW_I       = 1'b0;
	logic         AUX_SERIAL_I     = 1'b0;
	logic [7:0]   ERR_SET_I        = 8'h00;
	logic [7:0]   RDATA_O;
	logic [3:0]   CMD_O;
	logic         CMD_START_O;
	logic         IRQ_O;
	int           fails            = 0;
	int           cmp_count        = 0;
	int           cyc              = 0;
	logic [7:0]   g;
	logic [7:0]   a;
	logic [7:0]   d;
	logic [7:0]   e;

	// Code 1 left unknown to reach the unknown-command path
	irq_flags #(.CRC_CMD(4'h3), .KNOWN_CMDS(16'hFFFD)) dut (
		.CLK_I, .SRST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .EVT_I,
		.FIFO_HAS_BYTES_I, .FIFO_HIGH_I, .FIFO_LOW_I, .AUX_SERIAL_I, .ERR_SET_I,
		.CMD_O, .CMD_START_O, .IRQ_O
	);

	always #50 CLK_I = ~CLK_I;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [7:0] upd(logic [7:0] old, logic [7:0] v, logic [7:0] msk);
		return v[7] ? (old | (v & msk)) : (old & ~(v & msk));
	endfunction : upd

	task automatic chk(input logic [7:0] ex, input logic [7:0] got);
		cmp_count++;
		if (got !== ex) begin
			fails++;
			$display("Error at %0t: expected %h got %h", $time, ex, got);
		end
	endtask : chk

	task automatic wr(input logic [5:0] ad, input logic [7:0] v);
		@(posedge CLK_I);
		WR_I    <= 1'b1;
		ADDR_I  <= ad;
		WDATA_I <= v;
		@(posedge CLK_I);
		WR_I    <= 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [5:0] ad, input logic [7:0] ex);
		@(posedge CLK_I);
		RD_I   <= 1'b1;
		ADDR_I <= ad;
		@(posedge CLK_I);
		RD_I   <= 1'b0;
		#1;
		chk(ex, RDATA_O);
	endtask : rd_chk

	task automatic ev_chk(input unit_events_t ev, input logic [7:0] ex);
		wr(GEN_REQ_ADDR, 8'h7F);
		@(posedge CLK_I);
		EVT_I <= ev;
		@(posedge CLK_I);
		EVT_I <= '0;
		rd_chk(GEN_REQ_ADDR, ex);
	endtask : ev_chk

	task automatic finish_test;
		$display("Comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test

	// Whole run needs well under a thousand cycles
	always @(posedge CLK_I) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			finish_test();
		end
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		void'($urandom(32'hA804));
		repeat (20) @(posedge CLK_I);
		SRST_I <= 1'b0;
		rd_chk(GEN_REQ_ADDR, 8'h14);
		@(posedge CLK_I);
		#1;
		chk(8'h00, RDATA_O);
		rd_chk(AUX_REQ_ADDR, 8'h00);
		rd_chk(ERR_ADDR, 8'h00);
		rd_chk(6'h3F, 8'h00);
		chk(8'h01, {7'h00, IRQ_O});
		$display("Test reset done");
		g = 8'h14;
		a = 8'h00;
		for (int i = 0; i < 16; i++) begin
			d = 8'($urandom);
			if (i[0]) begin
				a = upd(a, d, 8'h14);
				wr(AUX_REQ_ADDR, d);
				rd_chk(AUX_REQ_ADDR, a);
			end else begin
				g = upd(g, d, 8'h7F);
				wr(GEN_REQ_ADDR, d);
				rd_chk(GEN_REQ_ADDR, g);
			end
		end
		$display("Test set select done");
		ev_chk(5'h10, 8'h40);
		ev_chk(5'h08, 8'h20);
		ev_chk(5'h02, 8'h01);
		wr(RX_MODE_ADDR, 8'h01);
		ev_chk(5'h08, 8'h00);
		@(posedge CLK_I);
		FIFO_HAS_BYTES_I <= 1'b1;
		ev_chk(5'h08, 8'h20);
		wr(RX_MODE_ADDR, 8'h00);
		$display("Test unit events done");
		wr(CMD_ADDR, 8'h05);
		#1;
		chk(8'h05, {4'h0, CMD_O});
		chk(8'h01, {7'h00, CMD_START_O});
		ev_chk(5'h04, 8'h10);
		chk(8'h00, {4'h0, CMD_O});
		ev_chk(5'h04, 8'h00);
		wr(GEN_REQ_ADDR, 8'h7F);
		wr(CMD_ADDR, 8'h00);
		rd_chk(GEN_REQ_ADDR, 8'h00);
		wr(CMD_ADDR, 8'h01);
		#1;
		chk(8'h00, {7'h00, CMD_START_O});
		rd_chk(GEN_REQ_ADDR, 8'h10);
		chk(8'h00, {4'h0, CMD_O});
		$display("Test commands done");
		wr(AUX_REQ_ADDR, 8'h14);
		ev_chk(5'h01, 8'h00);
		rd_chk(AUX_REQ_ADDR, 8'h00);
		wr(CMD_ADDR, 8'h03);
		ev_chk(5'h01, 8'h00);
		rd_chk(AUX_REQ_ADDR, 8'h04);
		for (int k = 0; k < 2; k++) begin
			wr(AUX_REQ_ADDR, 8'h14);
			@(posedge CLK_I);
			AUX_SERIAL_I <= ~AUX_SERIAL_I;
			@(posedge CLK_I);
			rd_chk(AUX_REQ_ADDR, 8'h10);
		end
		$display("Test aux requests done");
		for (int k = 0; k < 2; k++) begin
			wr(GEN_REQ_ADDR, 8'h7F);
			@(posedge CLK_I);
			{FIFO_HIGH_I, FIFO_LOW_I} <= k ? 2'b01 : 2'b10;
			@(posedge CLK_I);
			{FIFO_HIGH_I, FIFO_LOW_I} <= 2'b00;
			rd_chk(GEN_REQ_ADDR, k ? 8'h04 : 8'h08);
			wr(GEN_REQ_ADDR, k ? 8'h04 : 8'h08);
			rd_chk(GEN_REQ_ADDR, 8'h00);
		end
		$display("Test fifo alerts done");
		wr(CMD_ADDR, 8'h05);
		wr(GEN_REQ_ADDR, 8'h7F);
		e = (8'($urandom) & 8'h9F) | 8'h40;
		@(posedge CLK_I);
		ERR_SET_I <= e | 8'h20;
		@(posedge CLK_I);
		ERR_SET_I <= 8'h00;
		rd_chk(ERR_ADDR, e);
		rd_chk(GEN_REQ_ADDR, 8'h02);
		wr(ERR_ADDR, 8'hFF);
		rd_chk(ERR_ADDR, e);
		wr(CMD_ADDR, 8'h05);
		rd_chk(ERR_ADDR, 8'h40);
		$display("Test errors done");
		wr(GEN_EN_ADDR, 8'h01);
		wr(GEN_REQ_ADDR, 8'h7F);
		repeat (2) @(posedge CLK_I);
		#1;
		chk(8'h00, {7'h00, IRQ_O});
		ev_chk(5'h02, 8'h01);
		#1;
		chk(8'h01, {7'h00, IRQ_O});
		rd_chk(STATUS_ADDR, 8'h10);
		wr(GEN_EN_ADDR, 8'h81);
		repeat (2) @(posedge CLK_I);
		#1;
		chk(8'h00, {7'h00, IRQ_O});
		$display("Test interrupt pin done");
		finish_test();
	end

endmodule : irq_flags_bench
